// File: design/scom_pkg.sv
`default_nettype none
package scom_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned US_NS = 1000;
	localparam int unsigned TICK_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
	localparam int unsigned MS_US = 1000;
	localparam logic [9:0] MS_LAST = 10'(MS_US - 1);
	localparam int unsigned SERVO_MIN_US = 1000;
	localparam int unsigned SERVO_STEP_US = 4;
	localparam int unsigned SERVO_FRAME_US = 20000;
	localparam int unsigned NUM_LINES = 6;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] OFS_CHUFF_SRC = 12'h000;
	localparam logic [11:0] OFS_PER_CHUFF = 12'h004;
	localparam logic [11:0] OFS_PIN_CFG = 12'h008;
	localparam logic [11:0] OFS_LINE_MODE = 12'h00c;
	localparam logic [11:0] OFS_LINE_LEVEL = 12'h010;
	localparam logic [11:0] OFS_INT_PERIOD = 12'h014;
	localparam logic [11:0] OFS_SMOKE = 12'h018;
	localparam logic [11:0] OFS_STATUS = 12'h01c;
	localparam logic [11:0] OFS_SERVO_FIRST = 12'h020;
	localparam logic [11:0] OFS_SERVO_LAST = 12'h034;
	localparam logic [3:0] SERVO_WORD_BASE = 4'h8;

	// ****************************************
	// reset values and fields
	// ****************************************
	localparam logic [7:0] RST_CHUFF_SRC = 8'h01;
	localparam logic [7:0] RST_PER_CHUFF = 8'h01;
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam int unsigned WHEEL_EN_BIT = 4;
	localparam logic [11:0] RST_LINE_MODE = 12'ha00;
	localparam logic [6:0] RST_LINE_LEVEL = 7'h00;
	localparam int unsigned SHARED_LEVEL_BIT = 6;
	localparam logic [15:0] RST_INT_PERIOD = 16'h00fa;
	localparam logic [8:0] RST_SMOKE = 9'h000;
	localparam logic [7:0] RST_SERVO_POS = 8'h80;

	typedef enum logic [1:0] {
		SCOM_MODE_LOGIC = 2'b00,
		SCOM_MODE_SERVO = 2'b01,
		SCOM_MODE_SUSI = 2'b10
	} scom_mode_t;

	typedef struct packed {
		logic [7:0] source;
		logic [7:0] per_chuff;
		logic [15:0] period_ms;
	} scom_chuff_cfg_t;

	typedef struct packed {
		logic enable;
		logic [7:0] setpoint;
	} scom_smoke_cfg_t;
endpackage
`default_nettype wire

// File: design/scom_servo_gen.sv
`default_nettype none
module scom_servo_gen #(
	parameter int unsigned FRAME_US = scom_pkg::SERVO_FRAME_US
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick_us,
	input wire logic [5:0][7:0] pos,
	output logic [5:0] pulse
);
	logic [15:0] frame_cnt_reg;
	logic [5:0][7:0] pos_hold_reg;
	logic [5:0] pulse_reg;
	logic frame_wrap;

	assign frame_wrap = tick_us && (frame_cnt_reg == 16'(FRAME_US - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_cnt_reg <= 16'h0000;
		end else if (frame_wrap) begin
			frame_cnt_reg <= 16'h0000;
		end else if (tick_us) begin
			frame_cnt_reg <= frame_cnt_reg + 16'h0001;
		end
	end

	// positions latch at frame start so a write never chops a pulse
	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_ch
			logic [15:0] width;
			assign width = 16'(scom_pkg::SERVO_MIN_US) + 16'(pos_hold_reg[i]) * 16'(scom_pkg::SERVO_STEP_US);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pos_hold_reg[i] <= scom_pkg::RST_SERVO_POS;
					pulse_reg[i] <= 1'b0;
				end else begin
					if (frame_wrap) begin
						pos_hold_reg[i] <= pos[i];
					end
					pulse_reg[i] <= frame_cnt_reg < width;
				end
			end
		end
	endgenerate

	assign pulse = pulse_reg;

	property p_pulse_positive_start;
		@(posedge clk) disable iff (!rst_n)
		// skip the edge on which reset lets go: the pulse flops were still held low there
		$past(rst_n) && (frame_cnt_reg == 16'h0000) |=> (pulse_reg == 6'h3f);
	endproperty
	a_pulse_positive_start: assert property (p_pulse_positive_start) else $error("servo pulse not high at frame start");

	property p_pulse_min_width;
		@(posedge clk) disable iff (!rst_n)
		$rose(pulse_reg[0]) |-> pulse_reg[0] [*8];
	endproperty
	a_pulse_min_width: assert property (p_pulse_min_width) else $error("servo pulse too short");
endmodule
`default_nettype wire

// File: design/scom_top.sv
// The implementer's own choices: the register offsets and the APB slave port.
`default_nettype none
module scom_top #(
	parameter int unsigned SERVO_FRAME_US = scom_pkg::SERVO_FRAME_US
) (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// shared wheel sensor / auxiliary_output_nine pin
	input wire logic SHARED_PIN_IN,
	output logic SHARED_PIN_OUT,
	output logic SHARED_PIN_OE_OUT,
	// sound sensors and chuff
	input wire logic [1:0] SENSOR_IN,
	output logic [1:0] SOUND_TRIG_OUT,
	output logic CHUFF_TRIGGER_OUT,
	// output lines, 4 and 5 are the sound interface clock and data
	input wire logic SUSI_CLK_IN,
	input wire logic SUSI_DATA_IN,
	output logic [5:0] LINE_OUT,
	// smoke unit
	input wire logic [7:0] SMOKE_TEMP_IN,
	output logic HEATER_OUT
);
	// ****************************************
	// registers
	// ****************************************
	scom_pkg::scom_chuff_cfg_t chuff_cfg_reg;
	scom_pkg::scom_smoke_cfg_t smoke_cfg_reg;
	logic [7:0] pin_cfg_reg;
	logic [11:0] line_mode_reg;
	logic [6:0] line_level_reg;
	logic [5:0][7:0] servo_pos_reg;
	logic [31:0] prdata_reg;

	logic [5:0] tick_cnt_reg;
	logic [9:0] us_cnt_reg;
	logic [15:0] int_cnt_reg;
	logic [7:0] pulse_cnt_reg;
	logic [7:0] pulse_cnt_next;
	logic [7:0] chuff_total_reg;
	logic wheel_prev_reg;
	logic [1:0] sensor_prev_reg;
	logic [1:0] sound_trig_reg;
	logic chuff_reg;
	logic heater_reg;
	logic shared_out_reg;
	logic [5:0] line_reg;

	// ****************************************
	// apb decode
	// ****************************************
	wire apb_setup = PSEL_IN && !PENABLE_IN;
	wire apb_access = PSEL_IN && PENABLE_IN;
	wire apb_write = apb_access && PWRITE_IN;
	wire sel_src = PADDR_IN == scom_pkg::OFS_CHUFF_SRC;
	wire sel_per = PADDR_IN == scom_pkg::OFS_PER_CHUFF;
	wire sel_pin = PADDR_IN == scom_pkg::OFS_PIN_CFG;
	wire sel_mode = PADDR_IN == scom_pkg::OFS_LINE_MODE;
	wire sel_level = PADDR_IN == scom_pkg::OFS_LINE_LEVEL;
	wire sel_period = PADDR_IN == scom_pkg::OFS_INT_PERIOD;
	wire sel_smoke = PADDR_IN == scom_pkg::OFS_SMOKE;
	wire sel_status = PADDR_IN == scom_pkg::OFS_STATUS;
	wire sel_servo = (PADDR_IN >= scom_pkg::OFS_SERVO_FIRST) && (PADDR_IN <= scom_pkg::OFS_SERVO_LAST)
		&& (PADDR_IN[1:0] == 2'b00);
	wire [2:0] servo_idx = 3'(PADDR_IN[5:2] - scom_pkg::SERVO_WORD_BASE);
	wire mapped = sel_src || sel_per || sel_pin || sel_mode || sel_level || sel_period || sel_smoke
		|| sel_status || sel_servo;

	// ****************************************
	// chuff logic
	// ****************************************
	wire tick_us = tick_cnt_reg == scom_pkg::TICK_LAST;
	wire tick_ms = tick_us && (us_cnt_reg == scom_pkg::MS_LAST);
	wire ext_sel = chuff_cfg_reg.source == 8'h00;
	wire wheel_en = pin_cfg_reg[scom_pkg::WHEEL_EN_BIT];
	wire wheel_level = wheel_en && SHARED_PIN_IN;
	wire wheel_rise = wheel_level && !wheel_prev_reg;
	// a setting of zero acts as one: a chuff on every sensor pulse
	wire [7:0] per_eff = (chuff_cfg_reg.per_chuff == 8'h00) ? 8'h01 : chuff_cfg_reg.per_chuff;
	wire [8:0] cnt_plus = {1'b0, pulse_cnt_reg} + 9'h001;
	wire ext_hit = ext_sel && wheel_rise && (cnt_plus >= {1'b0, per_eff});
	wire [15:0] int_plus = int_cnt_reg + 16'h0001;
	wire int_run = !ext_sel && (chuff_cfg_reg.period_ms != 16'h0000);
	wire int_hit = int_run && tick_ms && (int_plus >= chuff_cfg_reg.period_ms);

	always_comb begin
		pulse_cnt_next = pulse_cnt_reg;
		if (!ext_sel) begin
			pulse_cnt_next = 8'h00;
		end else if (ext_hit) begin
			pulse_cnt_next = 8'h00;
		end else if (wheel_rise) begin
			pulse_cnt_next = cnt_plus[7:0];
		end
	end

	// ****************************************
	// line selection
	// ****************************************
	logic [5:0] servo_pulse;
	wire [5:0] susi_src = {SUSI_DATA_IN, SUSI_CLK_IN, 4'h0};
	wire [5:0] line_next;

	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_line
			wire [1:0] mode = line_mode_reg[2 * i +: 2];
			wire is_servo = mode == scom_pkg::SCOM_MODE_SERVO;
			wire is_susi = (mode == scom_pkg::SCOM_MODE_SUSI) && (i >= 4);
			assign line_next[i] = is_servo ? servo_pulse[i] :
				is_susi ? susi_src[i] : line_level_reg[i];
		end
	endgenerate

	scom_servo_gen #(
		.FRAME_US(SERVO_FRAME_US)
	) u_servo (
		.clk(CLK_IN),
		.rst_n(RESET_N_IN),
		.tick_us(tick_us),
		.pos(servo_pos_reg),
		.pulse(servo_pulse)
	);

	// ****************************************
	// read mux
	// ****************************************
	wire [31:0] status_word = {8'h00, SMOKE_TEMP_IN, chuff_total_reg, 3'h0, heater_reg, wheel_level,
		SENSOR_IN, ext_sel};
	wire [31:0] rd_mux = sel_src ? {24'h0, chuff_cfg_reg.source} :
		sel_per ? {24'h0, chuff_cfg_reg.per_chuff} :
		sel_pin ? {24'h0, pin_cfg_reg} :
		sel_mode ? {20'h0, line_mode_reg} :
		sel_level ? {25'h0, line_level_reg} :
		sel_period ? {16'h0, chuff_cfg_reg.period_ms} :
		sel_smoke ? {23'h0, smoke_cfg_reg} :
		sel_status ? status_word :
		sel_servo ? {24'h0, servo_pos_reg[servo_idx]} : 32'h0;

	// ****************************************
	// sequential
	// ****************************************
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			chuff_cfg_reg <= {scom_pkg::RST_CHUFF_SRC, scom_pkg::RST_PER_CHUFF, scom_pkg::RST_INT_PERIOD};
			smoke_cfg_reg <= scom_pkg::RST_SMOKE;
			pin_cfg_reg <= scom_pkg::RST_PIN_CFG;
			line_mode_reg <= scom_pkg::RST_LINE_MODE;
			line_level_reg <= scom_pkg::RST_LINE_LEVEL;
			servo_pos_reg <= {6{scom_pkg::RST_SERVO_POS}};
		end else if (apb_write) begin
			if (sel_src) chuff_cfg_reg.source <= PWDATA_IN[7:0];
			if (sel_per) chuff_cfg_reg.per_chuff <= PWDATA_IN[7:0];
			if (sel_period) chuff_cfg_reg.period_ms <= PWDATA_IN[15:0];
			if (sel_pin) pin_cfg_reg <= PWDATA_IN[7:0];
			if (sel_mode) line_mode_reg <= PWDATA_IN[11:0];
			if (sel_level) line_level_reg <= PWDATA_IN[6:0];
			if (sel_smoke) smoke_cfg_reg <= PWDATA_IN[8:0];
			if (sel_servo) servo_pos_reg[servo_idx] <= PWDATA_IN[7:0];
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			prdata_reg <= 32'h0;
		end else if (apb_setup) begin
			prdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			tick_cnt_reg <= 6'h00;
			us_cnt_reg <= 10'h000;
			int_cnt_reg <= 16'h0000;
		end else begin
			tick_cnt_reg <= tick_us ? 6'h00 : tick_cnt_reg + 6'h01;
			if (tick_us) us_cnt_reg <= (us_cnt_reg == scom_pkg::MS_LAST) ? 10'h000 : us_cnt_reg + 10'h001;
			if (!int_run) int_cnt_reg <= 16'h0000;
			else if (tick_ms) int_cnt_reg <= int_hit ? 16'h0000 : int_plus;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			pulse_cnt_reg <= 8'h00;
			wheel_prev_reg <= 1'b0;
			chuff_reg <= 1'b0;
			chuff_total_reg <= 8'h00;
		end else begin
			pulse_cnt_reg <= pulse_cnt_next;
			wheel_prev_reg <= wheel_level;
			chuff_reg <= ext_hit || int_hit;
			if (ext_hit || int_hit) chuff_total_reg <= chuff_total_reg + 8'h01;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sensor_prev_reg <= 2'b00;
			sound_trig_reg <= 2'b00;
			heater_reg <= 1'b0;
			shared_out_reg <= 1'b0;
			line_reg <= 6'h00;
		end else begin
			sensor_prev_reg <= SENSOR_IN;
			sound_trig_reg <= SENSOR_IN & ~sensor_prev_reg;
			// no hysteresis: the heater's own thermal mass smooths the switching
			heater_reg <= smoke_cfg_reg.enable && (SMOKE_TEMP_IN < smoke_cfg_reg.setpoint);
			shared_out_reg <= line_level_reg[scom_pkg::SHARED_LEVEL_BIT];
			line_reg <= line_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign PRDATA_OUT = prdata_reg;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = apb_access && !mapped;
	assign SHARED_PIN_OE_OUT = !wheel_en;
	assign SHARED_PIN_OUT = shared_out_reg;
	assign SOUND_TRIG_OUT = sound_trig_reg;
	assign CHUFF_TRIGGER_OUT = chuff_reg;
	assign LINE_OUT = line_reg;
	assign HEATER_OUT = heater_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	property p_ext_chuff_cause;
		CHUFF_TRIGGER_OUT && $past(ext_sel) |-> $past(wheel_rise);
	endproperty
	a_ext_chuff_cause: assert property (p_ext_chuff_cause) else $error("external chuff without sensor pulse");

	property p_internal_ignores_sensor;
		!ext_sel |=> pulse_cnt_reg == 8'h00;
	endproperty
	a_internal_ignores_sensor: assert property (p_internal_ignores_sensor) else $error("sensor counted in internal mode");

	sequence s_count_reached;
		ext_sel && wheel_rise && (cnt_plus >= {1'b0, per_eff});
	endsequence
	property p_chuff_on_count;
		s_count_reached |=> CHUFF_TRIGGER_OUT ##1 !CHUFF_TRIGGER_OUT || $past(int_hit);
	endproperty
	a_chuff_on_count: assert property (p_chuff_on_count) else $error("no chuff when count reached");

	property p_every_pulse;
		ext_sel && wheel_rise && (chuff_cfg_reg.per_chuff == 8'h01) |=> CHUFF_TRIGGER_OUT;
	endproperty
	a_every_pulse: assert property (p_every_pulse) else $error("setting one missed a chuff");

	property p_shared_pin;
		wheel_en |-> !SHARED_PIN_OE_OUT;
	endproperty
	a_shared_pin: assert property (p_shared_pin) else $error("shared pin driven while sensing");

	property p_logic_mode_level;
		(line_mode_reg[1:0] == 2'b00) |=> LINE_OUT[0] == $past(line_level_reg[0]);
	endproperty
	a_logic_mode_level: assert property (p_logic_mode_level) else $error("logic line not following level");

	property p_susi_clk_pass;
		(line_mode_reg[9:8] == 2'b10) |=> LINE_OUT[4] == $past(SUSI_CLK_IN);
	endproperty
	a_susi_clk_pass: assert property (p_susi_clk_pass) else $error("interface clock not passed");

	property p_heater;
		smoke_cfg_reg.enable && (SMOKE_TEMP_IN >= smoke_cfg_reg.setpoint) |=> !HEATER_OUT;
	endproperty
	a_heater: assert property (p_heater) else $error("heater on above setpoint");

	property p_sound_trig;
		$rose(SENSOR_IN[0]) |=> SOUND_TRIG_OUT[0] ##1 !SOUND_TRIG_OUT[0];
	endproperty
	a_sound_trig: assert property (p_sound_trig) else $error("sensor pulse not one cycle");

	property p_count_clears;
		ext_hit |=> pulse_cnt_reg == 8'h00;
	endproperty
	a_count_clears: assert property (p_count_clears) else $error("count not cleared on chuff");
endmodule
`default_nettype wire

// File: tb/scom_far_side.sv
`default_nettype none
module scom_far_side (
	// clock
	input wire logic clk_in,
	// wheel sensor, sound sensors, smoke temperature
	output logic wheel_out,
	output logic [1:0] sensor_out,
	output logic [7:0] temp_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int count = 0;
	initial begin
		wheel_out = 1'b0;
		sensor_out = 2'b00;
		temp_out = 8'h00;
	end
	// held three cycles so the level is seen on consecutive clocks
	task automatic wheel_pulse();
		@(posedge clk_in);
		wheel_out <= 1'b1;
		count++;
		repeat (3) @(posedge clk_in);
		wheel_out <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic sensor_pulse(input int idx);
		@(posedge clk_in);
		sensor_out[idx] <= 1'b1;
		repeat (3) @(posedge clk_in);
		sensor_out[idx] <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic set_temp(input logic [7:0] t);
		@(posedge clk_in);
		temp_out <= t;
	endtask
endmodule
`default_nettype wire

// File: tb/scom_top_tb_top.sv
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module scom_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [1:0] kind; logic [32:0] val;} scom_note_t;
	// ****************************************
	// signals and instances
	// ****************************************
	localparam int SERVO_CYC = (scom_pkg::SERVO_MIN_US + scom_pkg::SERVO_STEP_US * int'(scom_pkg::RST_SERVO_POS)) * 40;
	logic clk, rst_n, psel, penable, pwrite, susi_clk, susi_data, probe;
	logic pready, pslverr, shared_out, shared_oe, chuff, heater, wheel;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] sensor, trig;
	logic [5:0] lines;
	logic [7:0] temp;
	logic [6:0] r;
	scom_note_t notes[$];
	int num_errors = 0;
	int compares = 0;
	int pulses = 0;
	scom_top #(.SERVO_FRAME_US(3100)) dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .SHARED_PIN_IN(wheel), .SHARED_PIN_OUT(shared_out), .SHARED_PIN_OE_OUT(shared_oe),
		.SENSOR_IN(sensor), .SOUND_TRIG_OUT(trig), .CHUFF_TRIGGER_OUT(chuff), .SUSI_CLK_IN(susi_clk),
		.SUSI_DATA_IN(susi_data), .LINE_OUT(lines), .SMOKE_TEMP_IN(temp), .HEATER_OUT(heater));
	scom_far_side far (.clk_in(clk), .wheel_out(wheel), .sensor_out(sensor), .temp_out(temp));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic finish_test();
		$display("Errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic give_up();
		num_errors++;
		finish_test();
	endtask
	task automatic note(input logic [1:0] k, input logic [32:0] v);
		notes.push_back('{k, v});
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			if (++n > 50) give_up();
			@(posedge clk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		note(2'd0, e);
		apb(1'b0, a, 32'h0);
	endtask
	// probe vector: heater, pin enable, pin level, six lines
	task automatic look(input logic [8:0] e);
		note(2'd3, {24'h0, e});
		@(posedge clk);
		probe <= 1'b1;
		@(posedge clk);
		probe <= 1'b0;
	endtask
	task automatic spin(input int k, input int per);
		for (int i = 0; i < k; i++) begin
			pulses++;
			if (per > 0 && (i + 1) % per == 0) note(2'd1, 33'(pulses));
			far.wheel_pulse();
		end
	endtask
	task automatic take(input logic [1:0] k, input logic [32:0] got);
		scom_note_t n;
		if (notes.size() == 0) begin
			num_errors++;
			$display("Error at %0t: got %h expected none", $time, got);
		end else begin
			n = notes.pop_front();
			`CHK({k, got}, n)
		end
	endtask
	// ****************************************
	// result monitor
	// ****************************************
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) take(2'd0, {pslverr, prdata});
		if (chuff === 1'b1) take(2'd1, 33'(far.count));
		if (trig !== 2'b00) take(2'd2, {31'h0, trig});
		if (probe) take(2'd3, {24'h0, heater, shared_oe, shared_out, lines});
	end
	initial begin
		repeat (80000) @(posedge clk);
		give_up();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int n;
		int per;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		susi_clk = 1'b0;
		susi_data = 1'b0;
		probe = 1'b0;
		void'($urandom(59));
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		look(9'h080);
		wr(scom_pkg::OFS_LINE_MODE, 32'h555);
		// one internal chuff falls inside the servo wait, before any wheel pulse
		wr(scom_pkg::OFS_INT_PERIOD, 32'h1);
		note(2'd1, 33'h0);
		n = 0;
		while (lines !== 6'h3f) begin
			if (++n > 200) give_up();
			@(posedge clk);
		end
		n = 0;
		while (lines === 6'h3f) begin
			if (++n > 70000) give_up();
			@(posedge clk);
		end
		`CHK(n > SERVO_CYC - 120 && n <= SERVO_CYC, 1'b1)
		rd(scom_pkg::OFS_CHUFF_SRC, 33'h1);
		rd(scom_pkg::OFS_PER_CHUFF, 33'h1);
		rd(scom_pkg::OFS_PIN_CFG, 33'h0);
		rd(scom_pkg::OFS_SERVO_FIRST, 33'h80);
		rd(12'h040, {1'b1, 32'h0});
		r = 7'($urandom);
		susi_clk <= 1'($urandom);
		susi_data <= 1'($urandom);
		wr(scom_pkg::OFS_LINE_MODE, 32'haae);
		wr(scom_pkg::OFS_LINE_LEVEL, {25'h0, r});
		look({2'b01, r[6], susi_data, susi_clk, r[3:0]});
		wr(scom_pkg::OFS_LINE_MODE, 32'h000);
		look({2'b01, r});
		wr(scom_pkg::OFS_SMOKE, 32'h180);
		far.set_temp(8'h7f);
		look({2'b11, r});
		far.set_temp(8'h80);
		look({2'b01, r});
		for (int i = 0; i < 2; i++) begin
			note(2'd2, 33'(1 << i));
			far.sensor_pulse(i);
		end
		wr(scom_pkg::OFS_INT_PERIOD, 32'h0);
		wr(scom_pkg::OFS_PIN_CFG, 32'h10);
		look({2'b00, r});
		spin(3, 0);
		wr(scom_pkg::OFS_CHUFF_SRC, 32'h0);
		for (int i = 1; i <= 4; i++) begin
			per = (i < 4) ? i : 4 + int'($urandom % 4);
			wr(scom_pkg::OFS_PER_CHUFF, 32'(per));
			spin(2 * per, per);
		end
		wr(scom_pkg::OFS_PIN_CFG, 32'h0);
		spin(2, 0);
		// temp 0x80, nine chuffs in all, external source
		rd(scom_pkg::OFS_STATUS, {1'b0, 32'h0080_0901});
		repeat (10) @(posedge clk);
		`CHK(32'(notes.size()), 32'h0)
		finish_test();
	end
endmodule
`default_nettype wire
